// File: logic/cswdr_pkg.sv
// constants and types for the supervisor watchdog reset block
package cswdr_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // times in their own units, as printed
    localparam int unsigned RESET_HOLD_MS    = 610;  // typical, inside 250..1000 ms
    localparam int unsigned WD_LOW_MS        = 150;
    localparam int unsigned WD_OPEN_MS       = 600;
    localparam int unsigned WD_HIGH_MS       = 1200;
    localparam int unsigned BUTTON_IGNORE_MS = 1;
    localparam int unsigned BUTTON_MIN_MS    = 20;
    localparam int unsigned SUPPLY_FAIL_US   = 8;
    localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;
    // default cycle counts, derived from the times
    localparam int unsigned RESET_HOLD_CYC   = RESET_HOLD_MS * CYC_PER_MS;
    localparam int unsigned WD_LOW_CYC       = WD_LOW_MS * CYC_PER_MS;
    localparam int unsigned WD_OPEN_CYC      = WD_OPEN_MS * CYC_PER_MS;
    localparam int unsigned WD_HIGH_CYC      = WD_HIGH_MS * CYC_PER_MS;
    localparam int unsigned DEBOUNCE_CYC     = BUTTON_IGNORE_MS * CYC_PER_MS;
    localparam int unsigned SUPPLY_FAIL_CYC  = SUPPLY_FAIL_US * CLK_MHZ;
    localparam int unsigned CNT_W            = 32;
    // three-state period select, as sensed
    typedef enum logic [1:0] {
        CSWDR_SEL_LOW  = 2'h0,
        CSWDR_SEL_OPEN = 2'h1,
        CSWDR_SEL_HIGH = 2'h2
    } cswdr_sel_t;
    typedef enum logic [0:0] {
        CSWDR_RUN,
        CSWDR_HOLD
    } cswdr_state_t;
endpackage : cswdr_pkg

// File: logic/cswdr_top.sv
// supervisor: supply monitor, watchdog and debounced manual reset
// Summary of operation
// - both reset outputs assert while the supply-low indication is present.
// - the threshold select picks which supply-low comparator result is used, low 5%, high 10%.
// - the high reset output rises on supply low, watchdog expiry or a long manual reset.
// - the low reset output is always the complement of the high reset output.
// - after supply recovery or a watchdog timeout reset stays asserted one hold period.
// - the hold period is 610 ms, inside the 250 to 1000 ms window.
// - period select gives 150 ms low, 600 ms open, 1.2 s high.
// - the chosen periods lie inside their 62.5-250, 250-1000 and 500-2000 ms windows.
// - each strobe falling edge before expiry restarts the watchdog count from zero.
// - an expired watchdog asserts reset and holds it at least 250 ms.
// - a falling strobe transition counts as a restart once its low is sampled on a single clock edge.
// - the manual reset is debounced, ignoring lows under 1 ms and acting within 20 ms.
// - after the manual reset returns high reset stays asserted one more hold period.
// - a supply-low indication asserts reset within 8 us.
`timescale 1ns/100ps
module cswdr_top
    import cswdr_pkg::*;
#(
    parameter int unsigned RESET_HOLD = cswdr_pkg::RESET_HOLD_CYC,
    parameter int unsigned WD_LOW     = cswdr_pkg::WD_LOW_CYC,
    parameter int unsigned WD_OPEN    = cswdr_pkg::WD_OPEN_CYC,
    parameter int unsigned WD_HIGH    = cswdr_pkg::WD_HIGH_CYC,
    parameter int unsigned DEBOUNCE   = cswdr_pkg::DEBOUNCE_CYC
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  supply_low_5_in,
    input  wire logic                  supply_low_10_in,
    input  wire logic                  threshold_select_in,
    input  wire cswdr_pkg::cswdr_sel_t period_select_in,
    input  wire logic                  watchdog_strobe_n_in,
    input  wire logic                  manual_reset_in_n,
    output logic                       cpu_reset_out,
    output logic                       cpu_reset_n_out
);
    import cswdr_pkg::*;

    typedef struct packed {
        logic [1:0]        low5_sync;
        logic [1:0]        low10_sync;
        logic [1:0]        tol_sync;
        logic [3:0]        sel_sync;
        logic [2:0]        strobe_sync;   // two sync stages, third for edge detect
        logic [1:0]        button_sync;
        logic [CNT_W-1:0]  button_cnt;
        logic              button_down;   // debounced manual reset level
        logic [CNT_W-1:0]  wd_cnt;
        logic [CNT_W-1:0]  hold_cnt;
        cswdr_state_t      state;
        logic              rst;
    } cswdr_regs_t;

    cswdr_regs_t r;
    cswdr_regs_t next_r;

    function automatic logic [CNT_W-1:0] wd_limit(input logic [1:0] sel);
        case (sel)
            CSWDR_SEL_LOW:  wd_limit = CNT_W'(WD_LOW);
            CSWDR_SEL_HIGH: wd_limit = CNT_W'(WD_HIGH);
            default:        wd_limit = CNT_W'(WD_OPEN);
        endcase
    endfunction : wd_limit

    logic supply_low;
    logic strobe_fall;
    logic wd_expired;

    always_comb begin
        next_r = r;
        next_r.low5_sync   = {r.low5_sync[0], supply_low_5_in};
        next_r.low10_sync  = {r.low10_sync[0], supply_low_10_in};
        next_r.tol_sync    = {r.tol_sync[0], threshold_select_in};
        next_r.sel_sync    = {r.sel_sync[1:0], period_select_in};
        next_r.strobe_sync = {r.strobe_sync[1:0], watchdog_strobe_n_in};
        next_r.button_sync = {r.button_sync[0], manual_reset_in_n};

        // threshold choice made in logic; comparators sit outside
        supply_low  = r.tol_sync[1] ? r.low10_sync[1] : r.low5_sync[1];
        // edge taken between synchronised stages, so any low that lasts
        // at least a couple of clocks is seen; 75 ns is far above that
        strobe_fall = r.strobe_sync[2] & ~r.strobe_sync[1];

        // debounce: pin must hold its new level for the whole filter time;
        // button_down is the inverse of the pin level, so agreement means unequal
        if (r.button_sync[1] != r.button_down) begin
            next_r.button_cnt = '0;
        end else if (r.button_cnt >= CNT_W'(DEBOUNCE - 1)) begin
            next_r.button_cnt  = '0;
            next_r.button_down = ~r.button_sync[1];
        end else begin
            next_r.button_cnt = r.button_cnt + CNT_W'(1);
        end

        wd_expired = 1'b0;
        case (r.state)
            CSWDR_RUN: begin
                if (strobe_fall) begin
                    next_r.wd_cnt = '0;
                end else if (r.wd_cnt >= wd_limit(r.sel_sync[3:2]) - CNT_W'(1)) begin
                    wd_expired = 1'b1;
                end else begin
                    next_r.wd_cnt = r.wd_cnt + CNT_W'(1);
                end
                if (supply_low || wd_expired || r.button_down) begin
                    next_r.state    = CSWDR_HOLD;
                    next_r.rst      = 1'b1;
                    next_r.hold_cnt = '0;
                    next_r.wd_cnt   = '0;
                end
            end
            CSWDR_HOLD: begin
                next_r.wd_cnt = '0;
                // causes still present keep the hold timer at zero
                if (supply_low || r.button_down) begin
                    next_r.hold_cnt = '0;
                end else if (r.hold_cnt >= CNT_W'(RESET_HOLD - 1)) begin
                    next_r.state    = CSWDR_RUN;
                    next_r.rst      = 1'b0;
                    next_r.hold_cnt = '0;
                end else begin
                    next_r.hold_cnt = r.hold_cnt + CNT_W'(1);
                end
            end
            default: begin
                next_r.state = CSWDR_HOLD;
                next_r.rst   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            r             <= '0;
            r.strobe_sync <= 3'h7;
            r.button_sync <= 2'h3;
            r.state       <= CSWDR_HOLD;  // power-on acts as a supply recovery
            r.rst         <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign cpu_reset_out   = r.rst;
    assign cpu_reset_n_out = ~r.rst;
endmodule : cswdr_top

// File: test/cswdr_assertions.sv
// assertions on the supervisor watchdog reset ports
`timescale 1ns/100ps
module cswdr_checker
    import cswdr_pkg::*;
#(parameter int unsigned WD_LOW = 40, WD_OPEN = 80, WD_HIGH = 160, DEBOUNCE = 10) (
    input wire logic                  sys_clk_in,
    input wire logic                  reset_in,
    input wire logic                  supply_low_5_in,
    input wire logic                  supply_low_10_in,
    input wire logic                  threshold_select_in,
    input wire cswdr_pkg::cswdr_sel_t period_select_in,
    input wire logic                  watchdog_strobe_n_in,
    input wire logic                  manual_reset_in_n,
    input wire logic                  cpu_reset_out,
    input wire logic                  cpu_reset_n_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    logic        fail;
    logic [31:0] idle, low_cnt, lim;
    assign fail = threshold_select_in ? supply_low_10_in : supply_low_5_in;
    assign lim = period_select_in == CSWDR_SEL_LOW ? WD_LOW : period_select_in == CSWDR_SEL_HIGH ?
                 WD_HIGH : WD_OPEN;
    // counts from the strobe pin, the block sees the edge a few cycles later
    always_ff @(posedge sys_clk_in) begin
        idle    <= (reset_in || cpu_reset_out || $fell(watchdog_strobe_n_in)) ? '0 : idle + 1;
        low_cnt <= manual_reset_in_n ? '0 : low_cnt + 1;
    end
    complement_a: assert property (cpu_reset_n_out == !cpu_reset_out)
        else $error("not inverse");
    init_hold_a: assert property (disable iff (1'b0) reset_in |=> cpu_reset_out) else $error("init");
    supply_trip_a: assert property (fail [*4] |-> cpu_reset_out) else $error("late trip");
    supply_hold_a: assert property ($fell(cpu_reset_out) |-> !$past(fail, 40)) else $error("early");
    hold_time_a: assert property ($fell(cpu_reset_out) |-> $past(cpu_reset_out, 40)) else $error("short");
    wd_deadline_a: assert property (!cpu_reset_out |-> idle < lim + 8) else $error("no expiry");
    wd_early_a: assert property ($rose(cpu_reset_out) && !fail && manual_reset_in_n |-> idle + 4 >= lim)
        else $error("early expiry");
    button_trip_a: assert property (low_cnt == DEBOUNCE + 6 |-> cpu_reset_out) else $error("button");
    cover property ($rose(cpu_reset_out) && !fail && manual_reset_in_n);
    cover property (low_cnt == DEBOUNCE + 6);
    cover property ($fell(cpu_reset_out));
endmodule : cswdr_checker
bind cswdr_top cswdr_checker #(.WD_LOW(WD_LOW), .WD_OPEN(WD_OPEN), .WD_HIGH(WD_HIGH),
    .DEBOUNCE(DEBOUNCE)) u_checker (.*);

// File: test/cswdr_host.sv
// host processor model: strobes the watchdog while its firmware runs
`timescale 1ns/100ps
module cswdr_host (
    input  wire logic sys_clk_in,
    input  wire logic cpu_reset_in,
    input  wire logic run_in,
    output logic      strobe_n_out
);
    logic [7:0] cnt = 8'h00;
    initial strobe_n_out = 1'b1;
    // two-cycle low pulse every 21 cycles, held off while in reset or halted
    always @(posedge sys_clk_in) begin
        cnt          <= (cpu_reset_in || !run_in || cnt == 8'h14) ? 8'h00 : cnt + 8'h01;
        strobe_n_out <= cpu_reset_in || !run_in || cnt > 8'h01;
    end
endmodule : cswdr_host

// File: test/testbench.sv
// self-checking bench for the supervisor watchdog reset block
`timescale 1ns/100ps
module testbench;
    import cswdr_pkg::*;
    logic       sys_clk_in = 1'b0, reset_in = 1'b1, low5 = 1'b0, low10 = 1'b0, tsel = 1'b0;
    logic       btn_n = 1'b1, run = 1'b1, strobe_n, rst, rst_n;
    cswdr_sel_t psel = CSWDR_SEL_LOW;
    int         miscompares = 0, samples_checked = 0, cycles = 0, lims[3] = '{40, 80, 160};
    always #2 sys_clk_in = ~sys_clk_in;
    cswdr_top #(.RESET_HOLD(50), .WD_LOW(40), .WD_OPEN(80), .WD_HIGH(160), .DEBOUNCE(10)) DUT (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .supply_low_5_in(low5),
        .supply_low_10_in(low10), .threshold_select_in(tsel), .period_select_in(psel),
        .watchdog_strobe_n_in(strobe_n), .manual_reset_in_n(btn_n), .cpu_reset_out(rst),
        .cpu_reset_n_out(rst_n));
    cswdr_host host (.sys_clk_in(sys_clk_in), .cpu_reset_in(rst), .run_in(run),
        .strobe_n_out(strobe_n));
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : step
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // waits out the hold period, bounded
    task automatic released();
        repeat (300) if (rst !== 1'b0) step(1);
        chk(rst, 1'b0);
    endtask : released
    task automatic t_supply();
        for (int s = 0; s < 2; s++) begin
            tsel = s[0];
            if (s == 0) low10 = 1'b1; else low5 = 1'b1;
            step(10); chk(rst, 1'b0);
            if (s == 0) low5 = 1'b1; else low10 = 1'b1;
            step(4); chk(rst, 1'b1); chk(rst_n, 1'b0);
            low5 = 1'b0;
            low10 = 1'b0;
            step(40); chk(rst, 1'b1);
            released();
        end
    endtask : t_supply
    task automatic t_watchdog();
        for (int p = 0; p < 3; p++) begin
            psel = cswdr_sel_t'(p);
            step(400); chk(rst, 1'b0);
            @(negedge strobe_n);
            step(1);
            run = 1'b0;
            step(lims[p] - 6); chk(rst, 1'b0);
            step(16); chk(rst, 1'b1);
            step(30); chk(rst, 1'b1);
            run = 1'b1;
            released();
        end
    endtask : t_watchdog
    task automatic t_button();
        btn_n = 1'b0;
        step(5);
        btn_n = 1'b1;
        step(20); chk(rst, 1'b0);
        btn_n = 1'b0;
        step(20); chk(rst, 1'b1);
        step(100);
        btn_n = 1'b1;
        step(40); chk(rst, 1'b1);
        released();
    endtask : t_button
    task automatic stop_test();
        if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        step(12);
        reset_in = 1'b0;
        released();
        t_supply();
        t_watchdog();
        t_button();
        stop_test();
    end
endmodule : testbench
